// ==== logic/slb_pkg.sv ====
// Package for the serial link host bridge: framing, command codes, timing.
// Assumes a single 200 MHz clock domain.
package slb_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int DEFAULT_BAUD = 921600;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / DEFAULT_BAUD);
  localparam int CHAR_BITS = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int MS_US = 1000;
  localparam int CLK_PER_US = CLK_HZ / 1000000;
  localparam int MS_CYCLES = MS_US * CLK_PER_US;
  localparam logic [7:0] CMD_HELP = 8'h3f;
  localparam logic [7:0] CMD_BAUD = 8'h42;
  localparam logic [7:0] CMD_WAKE = 8'h54;
  localparam int BANNER_LEN = 16;
  localparam int I2C_INIT_LEN = 4;
  localparam int I2C_HALF = 250;
  localparam int WAKE_DIGITS = 11;
  typedef enum logic [2:0] {
    SLB_IDLE = 3'b000,
    SLB_BAUD = 3'b001,
    SLB_WAKE_ARGS = 3'b010,
    SLB_WAKE_READ = 3'b011,
    SLB_WAKE_WAIT = 3'b100,
    SLB_WAKE_WRITE = 3'b101,
    SLB_BANNER = 3'b110
  } slb_cmd_state_t;
endpackage

// ==== logic/slb_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/100ps
`default_nettype none
module slb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,              // System clock
  input wire logic reset_n_i,            // Sync reset, active low
  input wire logic enable_i,             // Clock enable
  input wire logic in_valid_i,           // Write request
  output logic in_ready_o,               // Not full
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  output logic out_valid_o,              // Not empty
  input wire logic out_ready_i,          // Read accept
  output logic [WIDTH-1:0] out_data_o    // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, rd_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o = mem[rd_reg[AW-1:0]];
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (enable_i) begin
      if (push) begin
        mem[wr_reg[AW-1:0]] <= in_data_i;
        wr_reg <= wr_reg + (AW+1)'(1);
      end
      if (pop) rd_reg <= rd_reg + (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ==== logic/slb_bridge.sv ====
// Host-side bridge: buffers host register traffic, relays link replies,
// runs local commands and the reset-time audio init sequence.
// Assumes byte-level serial ports with valid strobes, ready only on host transmit; bit timing is generated here
// only for the link transmitter and the I2C init engine.
`timescale 1ns/100ps
`default_nettype none
module slb_bridge (
  input wire logic clock_i,                    // 200 MHz system clock
  input wire logic reset_n_i,                  // Sync reset incl. reset switch
  input wire logic enable_i,                   // Clock enable, freezes all state
  input wire logic rts_i,                      // Host request-to-send
  input wire logic link_mode_select_i,         // High: bypass mode
  input wire logic control_direction_select_i, // High: host on this side
  input wire logic host_rx_valid_i,            // Host character strobe
  input wire logic [8:0] host_rx_data_i,       // Host character, 9 bits
  output logic host_tx_valid_o,                // Character to host valid
  input wire logic host_tx_ready_i,            // Host port can accept
  output logic [8:0] host_tx_data_o,           // Character to host
  input wire logic link_rx_valid_i,            // Character from link strobe
  input wire logic [8:0] link_rx_data_i,       // Character from link
  output logic link_tx_o,                      // Serial line toward link
  output logic link_busy_o,                    // Link transmitter busy
  output logic host_attached_o,                // Controlling host on this side
  output logic registers_reachable_o,          // Base mode active
  output logic [15:0] baud_divisor_value_o,    // Current bit divisor
  output logic audio_scl_o,                    // Audio I2C clock, low drive
  output logic audio_scl_oe_o,                 // Drives SCL low when high
  output logic audio_sda_o,                    // Audio I2C data, low drive
  output logic audio_sda_oe_o,                 // Drives SDA low when high
  output logic init_done_o                     // Audio init finished
);
  import slb_pkg::*;

  // Direction and mode reporting
  assign host_attached_o = control_direction_select_i;
  assign registers_reachable_o = !link_mode_select_i;

  // Character routing
  wire bypass = link_mode_select_i;
  // A full buffer refuses further host characters; they are lost, not stalled
  wire buffer_char = host_rx_valid_i && (rts_i || bypass);
  wire cmd_char = host_rx_valid_i && !rts_i && !bypass;
  wire [7:0] cmd_byte = host_rx_data_i[7:0];

  // Local command engine state
  slb_cmd_state_t state_reg, state_next;
  logic [15:0] div_reg;
  logic [3:0] digit_cnt_reg;
  logic [43:0] args_reg;
  logic [3:0] ms_left_reg;
  logic [17:0] ms_tick_reg;
  logic [4:0] ban_idx_reg;
  logic [1:0] wake_step_reg;

  assign baud_divisor_value_o = div_reg;

  // Hex digit decode
  wire [3:0] hex_val = (cmd_byte >= 8'h61) ? 4'(cmd_byte - 8'h57) :
                       (cmd_byte >= 8'h41) ? 4'(cmd_byte - 8'h37) : cmd_byte[3:0];
  // Argument digits, first one in the top nibble: AA RR D WW RR DD
  // Delay digit is clamped to 1..8 ms so that a zero never skips the wait
  wire [3:0] wake_delay = (args_reg[27:24] == 4'h0) ? 4'h1 :
                          (args_reg[27:24] > 4'h8) ? 4'h8 : args_reg[27:24];

  // Wake sequence bytes injected into the link stream
  logic [7:0] wake_byte;
  always_comb begin
    wake_byte = 8'h00;
    case ({state_reg == SLB_WAKE_WRITE, wake_step_reg})
      3'b000: wake_byte = args_reg[43:36];
      3'b001: wake_byte = args_reg[35:28];
      3'b010: wake_byte = 8'h01;
      3'b100: wake_byte = args_reg[23:16];
      3'b101: wake_byte = args_reg[15:8];
      3'b110: wake_byte = 8'h01;
      3'b111: wake_byte = args_reg[7:0];
      default: wake_byte = 8'h00;
    endcase
  end
  wire wake_sending = (state_reg == SLB_WAKE_READ) || (state_reg == SLB_WAKE_WRITE);
  wire [8:0] wake_char = {^wake_byte, wake_byte};

  // Host-to-link FIFO; held back while request-to-send stays asserted outside bypass mode
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [8:0] fifo_out_data;
  wire fifo_in_valid = buffer_char || wake_sending;
  // Host traffic wins the FIFO port; the wake step simply waits a cycle
  wire [8:0] fifo_in_data = buffer_char ? host_rx_data_i : wake_char;
  logic wake_push;
  assign wake_push = wake_sending && fifo_in_ready && !buffer_char;

  slb_fifo #(.WIDTH(CHAR_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(enable_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // Link transmitter: start, 9 data bits LSB first, 1.5 stop bits
  logic [3:0] tx_bit_reg;
  logic [15:0] tx_cnt_reg;
  logic [9:0] tx_sh_reg;
  logic tx_active_reg;
  wire release_ok = !rts_i || bypass;
  wire [15:0] half_div = {1'b0, div_reg[15:1]};
  wire [15:0] bit_len = (tx_bit_reg == 4'd10) ? 16'(div_reg + half_div) : div_reg;
  wire bit_end = tx_cnt_reg >= bit_len - 16'h0001;
  wire frame_end = tx_active_reg && bit_end && (tx_bit_reg == 4'd10);
  // A new character is loaded in the same cycle the stop ends: no gap
  assign fifo_out_ready = release_ok && (!tx_active_reg || frame_end);
  assign link_busy_o = tx_active_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tx_active_reg <= 1'b0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      tx_sh_reg <= 10'h3ff;
      link_tx_o <= 1'b1;
    end else if (enable_i) begin
      if (fifo_out_valid && fifo_out_ready) begin
        tx_active_reg <= 1'b1;
        tx_bit_reg <= 4'h0;
        tx_cnt_reg <= 16'h0000;
        tx_sh_reg <= {fifo_out_data, 1'b0};
        link_tx_o <= 1'b0;
      end else if (frame_end) begin
        tx_active_reg <= 1'b0;
        link_tx_o <= 1'b1;
      end else if (tx_active_reg) begin
        if (bit_end) begin
          tx_cnt_reg <= 16'h0000;
          tx_bit_reg <= tx_bit_reg + 4'h1;
          link_tx_o <= (tx_bit_reg == 4'd9) ? 1'b1 : tx_sh_reg[tx_bit_reg + 4'h1];
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 16'h0001;
        end
      end
    end
  end

  // Host transmit path: link replies win over the banner
  logic banner_valid;
  logic [7:0] banner_byte;
  logic tx_out_valid_reg;
  logic [8:0] tx_out_data_reg;
  wire host_slot_free = !tx_out_valid_reg || host_tx_ready_i;
  wire banner_take = banner_valid && !link_rx_valid_i && host_slot_free;
  assign host_tx_valid_o = tx_out_valid_reg;
  assign host_tx_data_o = tx_out_data_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tx_out_valid_reg <= 1'b0;
      tx_out_data_reg <= 9'h000;
    end else if (enable_i) begin
      if (link_rx_valid_i) begin
        // Link characters are never held back; a stalled host loses the older one
        tx_out_valid_reg <= 1'b1;
        tx_out_data_reg <= link_rx_data_i;
      end else if (banner_take) begin
        tx_out_valid_reg <= 1'b1;
        tx_out_data_reg <= {^banner_byte, banner_byte};
      end else if (host_tx_ready_i) begin
        tx_out_valid_reg <= 1'b0;
      end
    end
  end

  // Banner text and command list
  always_comb begin
    case (ban_idx_reg[3:0])
      4'h0: banner_byte = 8'h42; // B
      4'h1: banner_byte = 8'h52; // R
      4'h2: banner_byte = 8'h47; // G
      4'h3: banner_byte = 8'h20;
      4'h4: banner_byte = 8'h76; // v
      4'h5: banner_byte = 8'h31; // 1
      4'h6: banner_byte = 8'h0d;
      4'h7: banner_byte = 8'h0a;
      4'h8: banner_byte = 8'h3f; // ?
      4'h9: banner_byte = 8'h20;
      4'ha: banner_byte = 8'h42; // B
      4'hb: banner_byte = 8'h20;
      4'hc: banner_byte = 8'h54; // T
      4'hd: banner_byte = 8'h0d;
      4'he: banner_byte = 8'h0a;
      default: banner_byte = 8'h3e; // >
    endcase
  end
  assign banner_valid = state_reg == SLB_BANNER;

  // Command state machine
  wire wait_done = (ms_left_reg == 4'h0) && (ms_tick_reg == 18'h0);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLB_IDLE: begin
        if (cmd_char && cmd_byte == CMD_HELP) state_next = SLB_BANNER;
        else if (cmd_char && cmd_byte == CMD_BAUD) state_next = SLB_BAUD;
        else if (cmd_char && cmd_byte == CMD_WAKE) state_next = SLB_WAKE_ARGS;
        // Any other character leaves everything untouched
      end
      SLB_BAUD: if (cmd_char && digit_cnt_reg == 4'd3) state_next = SLB_IDLE;
      SLB_WAKE_ARGS: if (cmd_char && digit_cnt_reg == 4'(WAKE_DIGITS - 1)) state_next = SLB_WAKE_READ;
      SLB_WAKE_READ: if (wake_push && wake_step_reg == 2'd2) state_next = SLB_WAKE_WAIT;
      SLB_WAKE_WAIT: if (wait_done) state_next = SLB_WAKE_WRITE;
      SLB_WAKE_WRITE: if (wake_push && wake_step_reg == 2'd3) state_next = SLB_IDLE;
      SLB_BANNER: if (banner_take && ban_idx_reg == 5'(BANNER_LEN - 1)) state_next = SLB_IDLE;
      default: state_next = SLB_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_reg <= SLB_IDLE;
      div_reg <= DIV_RESET;
      digit_cnt_reg <= 4'h0;
      args_reg <= 44'h0;
      ms_left_reg <= 4'h0;
      ms_tick_reg <= 18'h0;
      ban_idx_reg <= 5'h0;
      wake_step_reg <= 2'h0;
    end else if (enable_i) begin
      state_reg <= state_next;
      if (state_reg == SLB_IDLE) begin
        digit_cnt_reg <= 4'h0;
        ban_idx_reg <= 5'h0;
        wake_step_reg <= 2'h0;
      end
      if ((state_reg == SLB_BAUD || state_reg == SLB_WAKE_ARGS) && cmd_char) begin
        digit_cnt_reg <= digit_cnt_reg + 4'h1;
        args_reg <= {args_reg[39:0], hex_val};
      end
      // Four hex digits form the new divisor, taken on the last one
      if (state_reg == SLB_BAUD && cmd_char && digit_cnt_reg == 4'd3)
        div_reg <= {args_reg[11:0], hex_val};
      if (wake_push) wake_step_reg <= wake_step_reg + 2'h1;
      if (state_reg == SLB_WAKE_READ && state_next == SLB_WAKE_WAIT) begin
        ms_left_reg <= wake_delay - 4'h1;
        ms_tick_reg <= 18'(MS_CYCLES - 1);
        wake_step_reg <= 2'h0;
      end else if (state_reg == SLB_WAKE_WAIT && !wait_done) begin
        if (ms_tick_reg == 18'h0) begin
          ms_tick_reg <= 18'(MS_CYCLES - 1);
          ms_left_reg <= ms_left_reg - 4'h1;
        end else begin
          ms_tick_reg <= ms_tick_reg - 18'h1;
        end
      end
      if (banner_take) ban_idx_reg <= ban_idx_reg + 5'h1;
    end
  end

  // Audio I2C init: fixed byte list, open-drain style outputs
  logic [7:0] init_rom;
  logic [2:0] init_idx_reg;
  logic [3:0] i2c_bit_reg;
  logic [1:0] i2c_phase_reg;
  logic [7:0] i2c_cnt_reg;
  logic init_done_reg;
  logic scl_low_reg, sda_low_reg;
  always_comb begin
    case (init_idx_reg)
      3'd0: init_rom = 8'h20;
      3'd1: init_rom = 8'h0a;
      3'd2: init_rom = 8'h80;
      3'd3: init_rom = 8'h01;
      default: init_rom = 8'h00;
    endcase
  end
  // Bit slots 0..7 data, 8 acknowledge (released), 9 stop
  wire i2c_data_bit = (i2c_bit_reg < 4'd8) ? init_rom[3'(4'd7 - i2c_bit_reg)] : 1'b1;
  assign audio_scl_o = 1'b0;
  assign audio_sda_o = 1'b0;
  assign audio_scl_oe_o = scl_low_reg;
  assign audio_sda_oe_o = sda_low_reg;
  assign init_done_o = init_done_reg;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      init_idx_reg <= 3'h0;
      i2c_bit_reg <= 4'h0;
      i2c_phase_reg <= 2'h0;
      i2c_cnt_reg <= 8'h0;
      init_done_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b1;                                  // start condition
    end else if (enable_i && !init_done_reg) begin
      if (i2c_cnt_reg != 8'(I2C_HALF - 1)) begin
        i2c_cnt_reg <= i2c_cnt_reg + 8'h1;
      end else begin
        i2c_cnt_reg <= 8'h0;
        i2c_phase_reg <= i2c_phase_reg + 2'h1;
        case (i2c_phase_reg)
          2'd0: if (i2c_bit_reg != 4'd10) scl_low_reg <= 1'b1;
          2'd1: sda_low_reg <= (i2c_bit_reg >= 4'd9) ? 1'b1 : !i2c_data_bit;
          2'd2: if (i2c_bit_reg != 4'd10) scl_low_reg <= 1'b0;
          default: begin
            if (i2c_bit_reg == 4'd9) begin
              sda_low_reg <= 1'b0;                          // stop
              if (init_idx_reg == 3'(I2C_INIT_LEN - 1)) begin
                init_done_reg <= 1'b1;
                i2c_bit_reg <= 4'h0;
              end else begin
                // Slot 10: bus-free gap, then a fresh start for the next byte
                i2c_bit_reg <= 4'd10;
              end
              init_idx_reg <= init_idx_reg + 3'h1;
            end else if (i2c_bit_reg == 4'd10) begin
              i2c_bit_reg <= 4'h0;                          // start held, clock follows
            end else begin
              i2c_bit_reg <= i2c_bit_reg + 4'h1;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/slb_bridge_asserts.sv ====
// Port checker for the serial link host bridge.
// Assumes it is bound onto slb_bridge, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module slb_bridge_asserts (
  input wire logic clock_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic enable_i, // Clock enable
  input wire logic rts_i, // Request-to-send
  input wire logic link_mode_select_i, // Bypass select
  input wire logic control_direction_select_i, // Direction select
  input wire logic host_rx_valid_i, // Host strobe
  input wire logic [8:0] host_rx_data_i, // Host char
  input wire logic host_tx_valid_o, // To host valid
  input wire logic host_tx_ready_i, // Host ready
  input wire logic [8:0] host_tx_data_o, // To host char
  input wire logic link_rx_valid_i, // Link strobe
  input wire logic [8:0] link_rx_data_i, // Link char
  input wire logic link_tx_o, // Serial line
  input wire logic link_busy_o, // Frame active
  input wire logic host_attached_o, // Host on this side
  input wire logic registers_reachable_o, // Base mode
  input wire logic [15:0] baud_divisor_value_o, // Divisor
  input wire logic audio_scl_o, // I2C clock
  input wire logic audio_scl_oe_o, // I2C clock enable
  input wire logic audio_sda_o, // I2C data
  input wire logic audio_sda_oe_o, // I2C data enable
  input wire logic init_done_o // Init finished
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  chk_mode_reach: assert property (registers_reachable_o == !link_mode_select_i)
    else $error("reachable flag does not follow mode select");
  chk_dir_attach: assert property (host_attached_o == control_direction_select_i)
    else $error("attached flag does not follow direction select");
  chk_relay_load: assert property (link_rx_valid_i && enable_i |=> host_tx_valid_o && host_tx_data_o == $past(link_rx_data_i))
    else $error("link char not relayed next cycle");
  chk_relay_hold: assert property (host_tx_valid_o && !host_tx_ready_i && !link_rx_valid_i |=> host_tx_valid_o && $stable(host_tx_data_o))
    else $error("host char dropped while stalled");
  chk_rts_hold: assert property (rts_i && !link_mode_select_i && !link_busy_o |=> !link_busy_o)
    else $error("frame started while buffering");
  chk_start_bit: assert property ($rose(link_busy_o) |-> (!link_tx_o) [*8])
    else $error("start bit missing or short");
  chk_idle_line: assert property (!link_busy_o |-> link_tx_o)
    else $error("line not high when idle");
  chk_div_steady: assert property (!host_rx_valid_i |=> $stable(baud_divisor_value_o))
    else $error("divisor moved without a host char");
  chk_rts_nocmd: assert property (rts_i && host_rx_valid_i |=> $stable(baud_divisor_value_o))
    else $error("command decoded while buffering");
  chk_i2c_release: assert property (init_done_o |-> !audio_sda_oe_o && !audio_scl_oe_o && !audio_scl_o && !audio_sda_o)
    else $error("audio bus not released after init");
  cov_relay: cover property (link_rx_valid_i && !host_tx_ready_i);
  cov_frame: cover property ($rose(link_busy_o));
  cov_init: cover property ($rose(init_done_o));
endmodule
bind slb_bridge slb_bridge_asserts u_slb_bridge_asserts (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .enable_i(enable_i), .rts_i(rts_i), .link_mode_select_i(link_mode_select_i),
  .control_direction_select_i(control_direction_select_i), .host_rx_valid_i(host_rx_valid_i),
  .host_rx_data_i(host_rx_data_i), .host_tx_valid_o(host_tx_valid_o), .host_tx_ready_i(host_tx_ready_i),
  .host_tx_data_o(host_tx_data_o), .link_rx_valid_i(link_rx_valid_i), .link_rx_data_i(link_rx_data_i),
  .link_tx_o(link_tx_o), .link_busy_o(link_busy_o), .host_attached_o(host_attached_o),
  .registers_reachable_o(registers_reachable_o), .baud_divisor_value_o(baud_divisor_value_o),
  .audio_scl_o(audio_scl_o), .audio_scl_oe_o(audio_scl_oe_o), .audio_sda_o(audio_sda_o),
  .audio_sda_oe_o(audio_sda_oe_o), .init_done_o(init_done_o));
`default_nettype wire

// ==== bench/slb_link_model.sv ====
// Link-side partner: decodes frames on the serial line, sends replies.
// Assumes the bridge's current divisor gives the bit period.
`timescale 1ns/100ps
`default_nettype none
module slb_link_model (
  input wire logic clock_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic line_i, // Serial line from bridge
  input wire logic [15:0] div_i, // Bit period in cycles
  output logic rx_valid_o, // Reply strobe
  output logic [8:0] rx_data_o // Reply char
);
  logic [8:0] rx_q[$];
  int gap_q[$];
  int cyc = 0;
  int last = -1;
  int errs = 0;
  always @(posedge clock_i) cyc <= cyc + 1;
  // Samples mid-bit; start-to-start spacing exposes any idle gap
  task automatic rx_frame();
    logic [8:0] ch;
    int start;
    start = cyc;
    repeat (div_i / 2) @(posedge clock_i);
    if (line_i !== 1'b0) errs++;
    for (int i = 0; i < 9; i++) begin
      repeat (div_i) @(posedge clock_i);
      ch[i] = line_i;
    end
    repeat (div_i) @(posedge clock_i);
    if (line_i !== 1'b1) errs++;
    rx_q.push_back(ch);
    if (last >= 0) gap_q.push_back(start - last);
    last = start;
  endtask
  task automatic reply(input logic [8:0] ch);
    @(posedge clock_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= ch;
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~ch;
  endtask
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 9'h000;
    forever begin
      @(posedge clock_i);
      if (reset_n_i && line_i === 1'b0) rx_frame();
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_slb_bridge.sv ====
// Self-checking bench for slb_bridge with a link-side partner.
// Assumes the checker is bound by its own file.
`timescale 1ns/100ps
`default_nettype none
module tb_slb_bridge;
  import slb_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0, rts_i = 1'b0, mode_i = 1'b0, cds_i = 1'b0;
  logic host_rx_valid_i = 1'b0, host_tx_ready_i = 1'b1;
  logic [8:0] host_rx_data_i = 9'h000;
  logic host_tx_valid_o, link_rx_valid_i, link_tx_o, link_busy_o, host_attached_o, registers_reachable_o;
  logic scl, scl_oe, sda, sda_oe, init_done_o;
  logic [8:0] host_tx_data_o, link_rx_data_i;
  logic [15:0] baud_divisor_value_o;
  logic [8:0] exp_q[$];
  int errors = 0, total_checks = 0, cycles = 0, tx_count = 0, div_set = 217, n;
  slb_bridge u_slb_bridge (.clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(1'b1), .rts_i(rts_i),
    .link_mode_select_i(mode_i), .control_direction_select_i(cds_i), .host_rx_valid_i(host_rx_valid_i),
    .host_rx_data_i(host_rx_data_i), .host_tx_valid_o(host_tx_valid_o), .host_tx_ready_i(host_tx_ready_i),
    .host_tx_data_o(host_tx_data_o), .link_rx_valid_i(link_rx_valid_i), .link_rx_data_i(link_rx_data_i),
    .link_tx_o(link_tx_o), .link_busy_o(link_busy_o), .host_attached_o(host_attached_o),
    .registers_reachable_o(registers_reachable_o), .baud_divisor_value_o(baud_divisor_value_o),
    .audio_scl_o(scl), .audio_scl_oe_o(scl_oe), .audio_sda_o(sda), .audio_sda_oe_o(sda_oe),
    .init_done_o(init_done_o));
  slb_link_model u_slb_link_model (.clock_i(clock_i), .reset_n_i(reset_n_i), .line_i(link_tx_o),
    .div_i(baud_divisor_value_o), .rx_valid_o(link_rx_valid_i), .rx_data_o(link_rx_data_i));
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (host_tx_valid_o === 1'b1 && host_tx_ready_i) tx_count++;
    if (cycles == 100000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] par(input logic [7:0] b);
    return {^b, b};
  endfunction
  task automatic send(input logic [8:0] ch);
    @(posedge clock_i);
    host_rx_valid_i <= 1'b1;
    host_rx_data_i <= ch;
    @(posedge clock_i);
    host_rx_valid_i <= 1'b0;
    host_rx_data_i <= ~ch;
  endtask
  task automatic send_str(input string s);
    foreach (s[i]) send(par(s[i]));
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  // Waits for the expected burst, then a little longer so that surplus frames show
  task automatic frames();
    int k;
    int g;
    k = 0;
    g = 11 * div_set + div_set / 2;
    while (u_slb_link_model.rx_q.size() < exp_q.size() && k < 20000) begin
      @(posedge clock_i);
      k++;
    end
    repeat (2 * g) @(posedge clock_i);
    check(16'(u_slb_link_model.rx_q.size()), 16'(exp_q.size()));
    foreach (u_slb_link_model.rx_q[i]) check(16'(u_slb_link_model.rx_q[i]), 16'(exp_q[i]));
    foreach (u_slb_link_model.gap_q[i]) check(16'(u_slb_link_model.gap_q[i]), 16'(g));
    u_slb_link_model.rx_q.delete();
    u_slb_link_model.gap_q.delete();
    u_slb_link_model.last = -1;
  endtask
  task automatic wait_init();
    for (int k = 0; k < 45000 && init_done_o !== 1'b1; k++) @(posedge clock_i);
    #1;
    check(16'(init_done_o), 16'h0001);
    check(16'({scl, sda, scl_oe, sda_oe}), 16'h0000);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check(baud_divisor_value_o, DIV_RESET);
    check(16'({sda_oe, scl_oe}), 16'h0002);
    wait_init();
    for (int v = 0; v < 2; v++) begin
      @(posedge clock_i);
      cds_i <= v[0];
      mode_i <= v[0];
      @(posedge clock_i);
      #1;
      check(16'(host_attached_o), 16'(v));
      check(16'(registers_reachable_o), 16'(!v));
    end
    mode_i <= 1'b0;
    send_str("B0020");
    div_set = 32;
    check(baud_divisor_value_o, 16'h0020);
    send_str("Z");
    check(baud_divisor_value_o, 16'h0020);
    rts_i <= 1'b1;
    send(par(8'h81));
    send(par(8'h05));
    send(par(8'h03));
    repeat (50) @(posedge clock_i);
    check(16'(link_busy_o), 16'h0000);
    rts_i <= 1'b0;
    exp_q = '{par(8'h81), par(8'h05), par(8'h03)};
    frames();
    // Ten chars into an eight-deep buffer: the last two are dropped
    rts_i <= 1'b1;
    send_str("B0010WXYZQ");
    check(baud_divisor_value_o, 16'h0020);
    rts_i <= 1'b0;
    exp_q = '{par("B"), par("0"), par("0"), par("1"), par("0"), par("W"), par("X"), par("Y")};
    frames();
    host_tx_ready_i <= 1'b0;
    rts_i <= 1'b1;
    u_slb_link_model.reply(9'h1a5);
    @(posedge clock_i);
    #1;
    check(16'(host_tx_valid_o), 16'h0001);
    check(16'(host_tx_data_o), 16'h01a5);
    n = tx_count;
    host_tx_ready_i <= 1'b1;
    rts_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    check(16'(tx_count - n), 16'h0001);
    n = tx_count;
    send_str("?");
    repeat (100) @(posedge clock_i);
    check(16'(tx_count - n), 16'(BANNER_LEN));
    check(16'(u_slb_link_model.rx_q.size()), 16'h0000);
    mode_i <= 1'b1;
    n = tx_count;
    send(9'h13f);
    exp_q = '{9'h13f};
    frames();
    check(16'(tx_count - n), 16'h0000);
    mode_i <= 1'b0;
    send_str("T81051800483");
    exp_q = '{par(8'h81), par(8'h05), par(8'h01)};
    frames();
    reset_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check(baud_divisor_value_o, DIV_RESET);
    check(16'(init_done_o), 16'h0000);
    wait_init();
    check(16'(u_slb_link_model.errs), 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
